// file: bench/demod_model.sv
// Demodulator and frame receiver stand-in.
// Assumes tasks are called from one bench process.
module demod_model (
  // Clock
  input logic clk_i,
  // Stream
  output logic nib_valid_o,
  output logic [3:0] nib_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  // Frame end
  output logic frame_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Model
  // ----------
  initial
  begin
    nib_valid_o = 1'b0;
    nib_o = 4'h0;
    byte_valid_o = 1'b0;
    byte_o = 8'h0;
    frame_done_o = 1'b0;
  end
  task automatic send_nib(input logic [3:0] v);
    @(posedge clk_i);
    nib_valid_o <= 1'b1;
    nib_o <= v;
    @(posedge clk_i);
    nib_valid_o <= 1'b0;
    nib_o <= ~v;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic send_byte(input logic [7:0] v);
    @(posedge clk_i);
    byte_valid_o <= 1'b1;
    byte_o <= v;
    @(posedge clk_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~v;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic end_frame;
    @(posedge clk_i);
    frame_done_o <= 1'b1;
    @(posedge clk_i);
    frame_done_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule // demod_model

// file: bench/sfd_detect_monitor.sv
// Port checks for the delimiter detector.
// Assumes one clock and a synchronous active-high reset.
`include "sfd_detect_consts.vh"
module sfd_detect_monitor (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Bus
  input logic cyc_i,
  input logic stb_i,
  input logic we_i,
  input logic ack_o,
  input logic [31:0] dat_o,
  // Stream and results
  input logic nib_valid_i,
  input logic byte_valid_i,
  input logic sfd_found_o,
  input logic sfd_timeout_o,
  input logic [2:0] rate_o,
  input logic len_valid_o,
  input logic [3:0] hdr_bytes_o,
  input logic opt_preamble_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("ack width");
  read_idle_a:
    assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
  header_count_a:
    assert property (sfd_found_o |-> hdr_bytes_o == ((rate_o == 3'h4) ? 4'hB : 4'h6))
      else $error("header length wrong");
  rate_code_a:
    assert property (sfd_found_o |-> rate_o <= 3'h4) else $error("rate code out of range");
  rate_hold_a:
    assert property (!$past(rst_i) && $changed(rate_o) |-> sfd_found_o) else $error("rate moved");
  found_cause_a:
    assert property (sfd_found_o |-> $past(nib_valid_i || byte_valid_i, 2))
      else $error("found without input");
  timeout_cause_a:
    assert property (sfd_timeout_o |-> $past(nib_valid_i || byte_valid_i, 2) && !sfd_found_o)
      else $error("timeout without input");
  found_once_a:
    assert property (sfd_found_o |=> !sfd_found_o [*3]) else $error("found repeated");
  length_cause_a:
    assert property (len_valid_o |-> $past(nib_valid_i || byte_valid_i))
      else $error("length without input");
  style_hold_a:
    assert property (!$past(rst_i) && $changed(opt_preamble_o) |->
      $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2))
      else $error("style moved");
endmodule // sfd_detect_monitor

bind sfd_detect sfd_detect_monitor sfd_detect_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .dat_o(dat_o),
  .nib_valid_i(nib_valid_i), .byte_valid_i(byte_valid_i), .sfd_found_o(sfd_found_o),
  .sfd_timeout_o(sfd_timeout_o), .rate_o(rate_o), .len_valid_o(len_valid_o),
  .hdr_bytes_o(hdr_bytes_o), .opt_preamble_o(opt_preamble_o));

// file: bench/testbench.sv
// Self-checking bench for the delimiter detector.
// Assumes a 25 MHz clock and the partner model on the stream side.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, nv, bv, fd;
  logic sfd_found_o, sfd_timeout_o, std_delim_o, len_valid_o, opt_preamble_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i, nib, hdr_bytes_o, hdr_seen;
  logic [31:0] dat_i, dat_o;
  logic [7:0] byt, len_o, len_seen, q;
  logic [2:0] rate_o, rate_seen;
  logic std_seen;
  int fail_count, checked, nf, nt, nl;
  logic [7:0] idx_t [10] = '{8'h36, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h70, 8'h10};
  logic [7:0] rst_t [10] = '{8'h03, 8'h21, 8'hF1, 8'h3B, 8'hE5, 8'h4D, 8'hA8, 8'hC8, 8'h01, 8'h00};
  logic [31:0] seq_t [7] = '{32'h0F21A8, 32'h0FF1C9, 32'h0F31C4, 32'h0F3B, 32'h0FE5, 32'h0FA7,
    32'h04DA9};
  int n_t [7] = '{3, 3, 3, 2, 2, 2, 5};
  int blk_t [7] = '{7, 6, 6, 5, 4, 3, 2};
  logic [2:0] rate_t [7] = '{3'h4, 3'h3, 3'h3, 3'h2, 3'h1, 3'h1, 3'h0};
  sfd_detect sfd_detect_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .nib_valid_i(nv), .nib_i(nib), .byte_valid_i(bv), .byte_i(byt), .frame_done_i(fd),
    .sfd_found_o(sfd_found_o), .sfd_timeout_o(sfd_timeout_o), .rate_o(rate_o),
    .std_delim_o(std_delim_o), .len_valid_o(len_valid_o), .len_o(len_o),
    .hdr_bytes_o(hdr_bytes_o), .opt_preamble_o(opt_preamble_o));
  demod_model dm_inst (.clk_i(clk_i), .nib_valid_o(nv), .nib_o(nib), .byte_valid_o(bv),
    .byte_o(byt), .frame_done_o(fd));
  // ----------
  // Bench
  // ----------
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(negedge clk_i)
  begin
    if (sfd_found_o === 1'b1)
    begin
      nf++;
      rate_seen = rate_o;
      std_seen = std_delim_o;
      hdr_seen = hdr_bytes_o;
    end
    if (sfd_timeout_o === 1'b1)
      nt++;
    if (len_valid_o === 1'b1)
    begin
      nl++;
      len_seen = len_o;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= {3'h0, s};
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack", 1, n < 20);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 1'b1);
    chk($sformatf("register %h", idx), e, q);
  endtask
  task automatic rx(input logic [31:0] s, input int n, input bit nb, input logic ef,
    input logic [2:0] er, input logic es, input logic et);
    nf = 0;
    nt = 0;
    nl = 0;
    for (int i = n - 1; i >= 0; i--)
      if (nb) dm_inst.send_nib(s[4*i+:4]);
      else dm_inst.send_byte(s[8*i+:8]);
    repeat (3) @(posedge clk_i);
    chk("found", ef, nf);
    chk("timeout", et, nt);
    if (ef)
    begin
      chk("rate", er, rate_seen);
      chk("standard", es, std_seen);
      chk("header", (er == 3'h4) ? 4'hB : 4'h6, hdr_seen);
      if (nb) dm_inst.send_nib(4'h5);
      if (nb) dm_inst.send_nib(4'hA);
      else dm_inst.send_byte(8'h5A);
      repeat (2) @(posedge clk_i);
      chk("length", 9'h15A, {nl[0], len_seen});
      dm_inst.end_frame();
    end
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
  initial
  begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd(idx_t[i], rst_t[i]);
    wb(1'b1, 8'h36, 8'h00, 1'b0);
    rd(8'h36, 8'h03);
    chk("style", 1, opt_preamble_o);
    for (int i = 0; i < 7; i++)
      rx(seq_t[i], n_t[i], i == 6, 1, rate_t[i], i == 5, 0);
    rx(32'h011111, 6, 1, 0, 0, 0, 1);
    rx(32'h0F111111, 4, 0, 0, 0, 0, 1);
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b1, 8'h36, 8'h02 | (8'h01 << blk_t[i]), 1'b1);
      rx(seq_t[i], n_t[i], i == 6, 0, 0, 0, 0);
    end
    wb(1'b1, 8'h36, 8'h00, 1'b1);
    repeat (3) @(posedge clk_i);
    chk("style", 0, opt_preamble_o);
    rx(32'h0F0FF1, 3, 0, 1, 3'h3, 0, 0);
    rx(32'h0F21, 2, 0, 1, 3'h4, 0, 0);
    dm_inst.send_byte(8'h21);
    rd(8'h70, 8'h0C);
    repeat (200) @(posedge clk_i);
    rd(8'h70, 8'h04);
    rx(32'h0F0FF0, 3, 0, 0, 0, 0, 0);
    wb(1'b1, 8'h61, 8'h9E, 1'b1);
    rd(8'h61, 8'h9E);
    rx(32'h0F0F9E, 3, 0, 1, 3'h3, 0, 0);
    complete_run();
  end
endmodule // testbench

// file: include/sfd_detect_consts.vh
// Constants for the multi-rate frame delimiter detector.
// Assumes a single 25 MHz receive clock and a word-wide register bus.
//
// Overview of operation
// - Payload byte time is 64, 32, 16, 8, 4 us from 125k up to 2M.
// - 2M has 8-byte preamble, 2-byte delimiter; others 4 and 1; length 1.
// - Rate of a frame comes from which delimiter pattern was recognized.
// - Disable bits 7, 6, 5, 2 block 2M, 1M, 500k, 125k frames.
// - At 250k bit 4 blocks proprietary delimiter, bit 3 the standard one.
// - Preamble style bit 1: one optimized, zero legacy; resets to one.
// - 2M uses pattern one alone, or pattern one over six when optimized.
// - 1M uses pattern two alone, or pattern two over seven when optimized.
// - 500k uses pattern three alone in either preamble style.
// - 250k uses pattern four when proprietary, else fixed value A7.
// - 125k uses pattern five over pattern six as a 16-bit delimiter.
// - 2M, 500k, 250k always match exactly; legacy 1M matches exactly.
// - 125k: latest four nibbles match pattern in at least three positions.
// - 125k: five nonzero nibbles without a match give timeout and reset.
// - 1M: bytes aligned from first preamble byte; word of two newest bytes.
// - 1M tolerates one bit, one 2-bit burst, or two separate 2-bit bursts.
// - 1M: three octets unlike 0F without a match give timeout and reset.
// - Preamble style is offered outward so channel assessment can shorten.
`ifndef SFD_DETECT_CONSTS_VH
`define SFD_DETECT_CONSTS_VH

// Register indices; byte address is four times the index
`define REG_RATE_CONFIG 8'h36
`define REG_PAT1 8'h60
`define REG_PAT2 8'h61
`define REG_PAT3 8'h62
`define REG_PAT4 8'h63
`define REG_PAT5 8'h64
`define REG_PAT6 8'h65
`define REG_PAT7 8'h66
`define REG_STATUS 8'h70

// Reset values
`define RST_RATE_CONFIG 8'h03
`define RST_PAT1 8'h21
`define RST_PAT2 8'hF1
`define RST_PAT3 8'h3B
`define RST_PAT4 8'hE5
`define RST_PAT5 8'h4D
`define RST_PAT6 8'hA8
`define RST_PAT7 8'hC8

// Rate configuration bit positions
`define BIT_BLK_2M 7
`define BIT_BLK_1M 6
`define BIT_BLK_500K 5
`define BIT_BLK_250K_PROP 4
`define BIT_BLK_250K_STD 3
`define BIT_BLK_125K 2
`define BIT_OPT 1

// Fixed patterns
`define STD_DELIM 8'hA7
`define PRE_NIBBLE 4'h0
`define PRE_OCTET_1M 8'h0F

// Rate codes
`define RATE_125K 3'h0
`define RATE_250K 3'h1
`define RATE_500K 3'h2
`define RATE_1M 3'h3
`define RATE_2M 3'h4

// Timing
`define CLK_MHZ 25
`define BT_125K_US 64
`define BT_250K_US 32
`define BT_500K_US 16
`define BT_1M_US 8
`define BT_2M_US 4
`define BT_CYC(us) ((us) * `CLK_MHZ)
`define LEN_WAIT_BYTES 2

// Header length in byte times
`define PRE_BYTES_2M 4'h8
`define DLM_BYTES_2M 4'h2
`define PRE_BYTES 4'h4
`define DLM_BYTES 4'h1
`define LEN_BYTES 4'h1

`endif

// file: rtl/burst_tolerant_match.v
// Approximate word compare tolerating short error bursts.
// Assumes both operands are stable in the cycle they are compared.
module burst_tolerant_match #(
  parameter WIDTH = 16
) (
  // Operands
  input wire [WIDTH-1:0] word_i,
  input wire [WIDTH-1:0] pattern_i,
  // Result
  output wire match_o
);

  wire [WIDTH-1:0] err;
  wire [WIDTH-1:0] pair_ok;
  reg [4:0] weight;
  integer i;

  assign err = word_i ^ pattern_i;

  // Each error bit has exactly one erroneous circular neighbour
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_pair
      assign pair_ok[g] = ~err[g] |
        (err[(g + 1) % WIDTH] ^ err[(g + WIDTH - 1) % WIDTH]);
    end
  endgenerate

  always @*
  begin
    weight = 5'h00;
    for (i = 0; i < WIDTH; i = i + 1)
      weight = weight + {4'h0, err[i]};
  end

  // At most one error bit, or two or four error bits in 2-bit bursts
  assign match_o = (weight <= 5'h01) |
    ((&pair_ok) & ((weight == 5'h02) | (weight == 5'h04)));

endmodule // burst_tolerant_match

// file: rtl/sfd_detect.v
// Multi-rate receive delimiter detector with register file.
// Assumes aligned demodulator nibbles and bytes, and a classic Wishbone master.
//
// Chosen here: the Wishbone register port.
`include "sfd_detect_consts.vh"

module sfd_detect (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [9:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Demodulator
  input wire nib_valid_i,
  input wire [3:0] nib_i,
  input wire byte_valid_i,
  input wire [7:0] byte_i,
  // Frame receiver
  input wire frame_done_i,
  output reg sfd_found_o,
  output reg sfd_timeout_o,
  output reg [2:0] rate_o,
  output reg std_delim_o,
  output reg len_valid_o,
  output reg [7:0] len_o,
  output reg [3:0] hdr_bytes_o,
  output reg opt_preamble_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_SEARCH = 2'h0;
  localparam [1:0] ST_LEN = 2'h1;
  localparam [1:0] ST_FRAME = 2'h2;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [2:0] nib_hits;
    input [15:0] a;
    input [15:0] b;
    begin
      nib_hits = {2'h0, a[15:12] == b[15:12]} + {2'h0, a[11:8] == b[11:8]} +
        {2'h0, a[7:4] == b[7:4]} + {2'h0, a[3:0] == b[3:0]};
    end
  endfunction

  function [11:0] byte_cycles;
    input [2:0] rate;
    reg [31:0] cyc;
    begin
      case (rate)
        `RATE_125K: cyc = `BT_CYC(`BT_125K_US);
        `RATE_250K: cyc = `BT_CYC(`BT_250K_US);
        `RATE_500K: cyc = `BT_CYC(`BT_500K_US);
        `RATE_1M: cyc = `BT_CYC(`BT_1M_US);
        default: cyc = `BT_CYC(`BT_2M_US);
      endcase
      byte_cycles = cyc[11:0];
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] rate_config_q;
  reg [7:0] pat_q [1:7];
  reg [1:0] state_q;
  reg [15:0] nib_hist_q;
  reg [2:0] nib_cnt_q;
  reg [4:0] nib_nz_q;
  reg nib_armed_q;
  reg [23:0] byte_hist_q;
  reg [1:0] byte_cnt_q;
  reg [2:0] oct_bad_q;
  reg byte_armed_q;
  reg len_half_q;
  reg [11:0] wait_q;
  reg [1:0] wait_bytes_q;
  reg [7:0] adr_idx;
  reg [7:0] rd_data;
  integer k;

  wire blk_2m = rate_config_q[`BIT_BLK_2M];
  wire blk_1m = rate_config_q[`BIT_BLK_1M];
  wire blk_500k = rate_config_q[`BIT_BLK_500K];
  wire blk_250k_prop = rate_config_q[`BIT_BLK_250K_PROP];
  wire blk_250k_std = rate_config_q[`BIT_BLK_250K_STD];
  wire blk_125k = rate_config_q[`BIT_BLK_125K];
  wire opt = rate_config_q[`BIT_OPT];

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire bus_wr = bus_req & we_i & sel_i[0];

  always @*
  begin
    adr_idx = adr_i[9:2];
    case (adr_idx)
      `REG_RATE_CONFIG: rd_data = rate_config_q;
      `REG_PAT1: rd_data = pat_q[1];
      `REG_PAT2: rd_data = pat_q[2];
      `REG_PAT3: rd_data = pat_q[3];
      `REG_PAT4: rd_data = pat_q[4];
      `REG_PAT5: rd_data = pat_q[5];
      `REG_PAT6: rd_data = pat_q[6];
      `REG_PAT7: rd_data = pat_q[7];
      `REG_STATUS: rd_data = {3'h0, state_q, rate_o};
      default: rd_data = 8'h00;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      rate_config_q <= `RST_RATE_CONFIG;
      pat_q[1] <= `RST_PAT1;
      pat_q[2] <= `RST_PAT2;
      pat_q[3] <= `RST_PAT3;
      pat_q[4] <= `RST_PAT4;
      pat_q[5] <= `RST_PAT5;
      pat_q[6] <= `RST_PAT6;
      pat_q[7] <= `RST_PAT7;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= bus_req ? {24'h000000, rd_data} : 32'h00000000;
      if (bus_wr)
      begin
        if (adr_idx == `REG_RATE_CONFIG)
          rate_config_q <= dat_i[7:0];
        for (k = 1; k <= 7; k = k + 1)
          if (adr_idx == `REG_PAT1 + k[7:0] - 8'h01)
            pat_q[k] <= dat_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // Delimiter matching
  // ----------------------------------------
  wire [15:0] word = byte_hist_q[15:0];
  wire [15:0] nib_word = nib_hist_q;
  wire word_ok = byte_cnt_q == 2'h2;
  wire tol_1m;

  burst_tolerant_match #(
    .WIDTH(16)
  ) u_tol_1m (
    .word_i(word),
    .pattern_i({pat_q[2], pat_q[7]}),
    .match_o(tol_1m)
  );

  wire hit_2m = ~blk_2m & (opt ? (word_ok & word == {pat_q[1], pat_q[6]})
    : (word[7:0] == pat_q[1]));
  wire hit_1m = ~blk_1m & (opt ? (word_ok & tol_1m) : (word[7:0] == pat_q[2]));
  wire hit_500k = ~blk_500k & (word[7:0] == pat_q[3]);
  wire hit_250p = ~blk_250k_prop & (word[7:0] == pat_q[4]);
  wire hit_250s = ~blk_250k_std & (word[7:0] == `STD_DELIM);
  wire hit_byte = hit_2m | hit_1m | hit_500k | hit_250p | hit_250s;
  wire hit_125k = ~blk_125k & (nib_cnt_q >= 3'h4) &
    (nib_hits(nib_word, {pat_q[5], pat_q[6]}) >= 3'h3);

  // Timeout terms look at the histories after the newest input
  wire to_125k = nib_armed_q & (&nib_nz_q) & (nib_cnt_q >= 3'h5) & ~hit_125k;
  wire to_1m = byte_armed_q & (&oct_bad_q) & ~hit_byte;

  // ----------------------------------------
  // Sample pulse alignment
  // ----------------------------------------
  reg nib_new_q;
  reg byte_new_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nib_new_q <= 1'b0;
      byte_new_q <= 1'b0;
    end
    else
    begin
      nib_new_q <= nib_valid_i;
      byte_new_q <= byte_valid_i;
    end
  end

  // ----------------------------------------
  // Search, length and frame sequencing
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_SEARCH;
      nib_hist_q <= 16'h0000;
      nib_cnt_q <= 3'h0;
      nib_nz_q <= 5'h00;
      nib_armed_q <= 1'b0;
      byte_hist_q <= 24'h000000;
      byte_cnt_q <= 2'h0;
      oct_bad_q <= 3'h0;
      byte_armed_q <= 1'b0;
      len_half_q <= 1'b0;
      wait_q <= 12'h000;
      wait_bytes_q <= 2'h0;
      sfd_found_o <= 1'b0;
      sfd_timeout_o <= 1'b0;
      rate_o <= `RATE_250K;
      std_delim_o <= 1'b0;
      len_valid_o <= 1'b0;
      len_o <= 8'h00;
      hdr_bytes_o <= 4'h0;
      opt_preamble_o <= 1'b1;
    end
    else
    begin
      sfd_found_o <= 1'b0;
      sfd_timeout_o <= 1'b0;
      len_valid_o <= 1'b0;
      opt_preamble_o <= opt;
      case (state_q)
        ST_SEARCH:
        begin
          if (nib_valid_i)
          begin
            nib_hist_q <= {nib_hist_q[11:0], nib_i};
            nib_nz_q <= {nib_nz_q[3:0], nib_i != `PRE_NIBBLE};
            if (nib_cnt_q != 3'h5)
              nib_cnt_q <= nib_cnt_q + 3'h1;
            if (nib_i == `PRE_NIBBLE)
              nib_armed_q <= 1'b1;
          end
          if (byte_valid_i)
          begin
            byte_hist_q <= {byte_hist_q[15:0], byte_i};
            oct_bad_q <= {oct_bad_q[1:0], byte_i != `PRE_OCTET_1M};
            if (byte_cnt_q != 2'h2)
              byte_cnt_q <= byte_cnt_q + 2'h1;
            if (byte_i == `PRE_OCTET_1M)
              byte_armed_q <= 1'b1;
          end
          if (byte_new_q & hit_byte)
          begin
            sfd_found_o <= 1'b1;
            state_q <= ST_LEN;
            std_delim_o <= 1'b0;
            if (hit_2m)
              rate_o <= `RATE_2M;
            else if (hit_1m)
              rate_o <= `RATE_1M;
            else if (hit_500k)
              rate_o <= `RATE_500K;
            else
            begin
              rate_o <= `RATE_250K;
              std_delim_o <= ~hit_250p;
            end
            hdr_bytes_o <= hit_2m ? (`PRE_BYTES_2M + `DLM_BYTES_2M + `LEN_BYTES)
              : (`PRE_BYTES + `DLM_BYTES + `LEN_BYTES);
          end
          else if (nib_new_q & hit_125k)
          begin
            sfd_found_o <= 1'b1;
            state_q <= ST_LEN;
            rate_o <= `RATE_125K;
            std_delim_o <= 1'b0;
            hdr_bytes_o <= `PRE_BYTES + `DLM_BYTES + `LEN_BYTES;
          end
          else if ((nib_new_q & to_125k) | (byte_new_q & to_1m))
          begin
            sfd_timeout_o <= 1'b1;
            nib_cnt_q <= 3'h0;
            nib_nz_q <= 5'h00;
            nib_armed_q <= 1'b0;
            byte_cnt_q <= 2'h0;
            oct_bad_q <= 3'h0;
            byte_armed_q <= 1'b0;
          end
          wait_q <= 12'h000;
          wait_bytes_q <= 2'h0;
          len_half_q <= 1'b0;
        end
        ST_LEN:
        begin
          // Length arrives as one byte, or two nibbles high first at 125k
          if (rate_o == `RATE_125K)
          begin
            if (nib_valid_i)
            begin
              len_o <= {len_o[3:0], nib_i};
              len_half_q <= ~len_half_q;
              if (len_half_q)
              begin
                len_valid_o <= 1'b1;
                state_q <= ST_FRAME;
              end
            end
          end
          else if (byte_valid_i)
          begin
            len_o <= byte_i;
            len_valid_o <= 1'b1;
            state_q <= ST_FRAME;
          end
          // Give up if the length field does not arrive in time
          if (wait_q == byte_cycles(rate_o) - 12'h001)
          begin
            wait_q <= 12'h000;
            wait_bytes_q <= wait_bytes_q + 2'h1;
            if (wait_bytes_q == `LEN_WAIT_BYTES - 1)
              state_q <= ST_SEARCH;
          end
          else
            wait_q <= wait_q + 12'h001;
        end
        ST_FRAME:
        begin
          if (frame_done_i)
            state_q <= ST_SEARCH;
        end
        default:
          state_q <= ST_SEARCH;
      endcase
      // Clean histories whenever a new search begins
      if (state_q != ST_SEARCH)
      begin
        nib_cnt_q <= 3'h0;
        nib_nz_q <= 5'h00;
        nib_armed_q <= 1'b0;
        byte_cnt_q <= 2'h0;
        oct_bad_q <= 3'h0;
        byte_armed_q <= 1'b0;
        byte_hist_q <= 24'h000000;
        nib_hist_q <= 16'h0000;
      end
    end
  end

endmodule // sfd_detect
